// >>> rfm_params.svh
// Register map, codes and timing constants for the option-mode handler
`ifndef RFM_PARAMS_SVH
`define RFM_PARAMS_SVH
`define RFM_OFS_CTRL 8'h00
`define RFM_OFS_STATUS 8'h04
`define RFM_OFS_RESULT 8'h08
`define RFM_CTRL_LEN_BIT 0
`define RFM_CTRL_EN_BIT 1
`define RFM_CTRL_RST 2'h2
`define RFM_ST_FIELD_BIT 4
`define RFM_ST_INHIB_BIT 5
`define RFM_ST_FRAME_BIT 6
`define RFM_ST_SLEEP_BIT 7
`define RFM_RS_CMD_LSB 8
`define RFM_RS_OPT_LSB 16
`define RFM_EC_OK 8'h00
`define RFM_EC_PAR 8'h10
`define RFM_EC_FRM 8'h11
`define RFM_EC_OVR 8'h12
`define RFM_EC_BCC 8'h13
`define RFM_EC_FMT 8'h14
`define RFM_EC_FRAME 8'h18
`define RFM_EC_COMM 8'h70
`define RFM_EC_WRT 8'h71
`define RFM_EC_NOTAG 8'h72
`define RFM_EC_HW 8'h7c
`define RFM_CMD_READ 8'h01
`define RFM_CMD_WSAME 8'h03
`define RFM_CMD_SNUM 8'h05
`define RFM_CMD_LOCK 8'h09
`define RFM_CMD_TEST 8'h10
`define RFM_CMD_ACK 8'h11
`define RFM_CMD_NAK 8'h12
`define RFM_CMD_STOP 8'h13
`define RFM_CMD_EAS 8'h24
`define RFM_CH_CR 8'h0d
`define RFM_CH_STX 8'h02
`define RFM_CH_0 8'h30
`define RFM_CH_9 8'h39
`define RFM_CH_A 8'h41
`define RFM_CH_F 8'h46
`define RFM_OPT_RSV_MSB 7
`define RFM_OPT_RSV_LSB 5
`define RFM_OPT_CODE_BIT 4
`define RFM_OPT_MODE_MSB 3
`define RFM_MODE_ANTI_BIT 3
`define RFM_MODE_STRIG 4'h0
`define RFM_MODE_SAUTO 4'h1
`define RFM_MODE_SREP 4'h2
`define RFM_MODE_FTRIG 4'h8
`define RFM_MODE_FAUTO 4'h9
`define RFM_MODE_FCONT 4'ha
`define RFM_MODE_FREP 4'hb
`define RFM_TR_OK 2'h0
`define RFM_TR_COMM 2'h1
`define RFM_TR_WRT 2'h2
`define RFM_TR_HW 2'h3
`define RFM_MAX_CHARS 140
`define RFM_GAP_MS 2000
`define RFM_CLK_HZ 40000000
`define RFM_GAP_CYC (`RFM_GAP_MS * (`RFM_CLK_HZ / 1000))
`endif

// >>> rfm_pkg.sv
// Types shared by the option-mode handler
package rfm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACCESS, ST_ACK} rfm_state_t;
  typedef enum logic [1:0] {FL_COUNT, FL_CMD, FL_OPT, FL_PAR} rfm_field_t;
endpackage : rfm_pkg

// >>> rfm_mode_handler.sv
// Option-byte interpreter and tag-access mode sequencer with AHB-Lite registers
// Function
// - In terminator framing, data code 0 pairs two hex characters into one byte.
// - Data code 1 stores each character code as one byte.
// - Mode 0 accesses at once, answers, then sleeps.
// - Modes 0 and 8 answer no-tag when no tag is present.
// - Mode 1 waits for a tag, accesses, answers, sleeps.
// - Stop while waiting for a tag ends the pending command.
// - Modes 2 and B repeat the command until stop.
// - Anti-collision modes inhibit tags already served.
// - Inhibit holds field on unmodulated; stop ends oscillation.
// - Modes 8 and 9 sleep after answering; 9 waits first.
// - Mode A waits for host acknowledge before next tag.
// - Character parity, framing, overrun faults give 10, 11, 12.
// - Length framing with bad block check byte gives 13.
// - Malformed command gives format code 14.
// - Over 140 characters, or 2 s gap in terminator framing, gives 18.
// - Tag link interference gives 70.
// - Write to protected or worn area gives 71.
// - No tag at execution gives 72; hardware fault gives 7C.
// - Success puts 00 at the head of the response.
// - Stop command ends execution and halts oscillation.
`timescale 1ns/1ps
`include "rfm_params.svh"
module rfm_mode_handler #(
  parameter int GAP_CYCLES = `RFM_GAP_CYC,
  parameter int GAP_W = 27,
  parameter int MAX_CHARS = `RFM_MAX_CHARS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_overrun_err_i,
  input wire logic tag_present_i,
  input wire logic tag_done_i,
  input wire logic [1:0] tag_result_i,
  output logic tag_start_o,
  output logic tag_stop_o,
  output logic [7:0] tag_cmd_o,
  output logic [3:0] tag_mode_o,
  output logic tag_inhibit_o,
  output logic field_on_o,
  output logic sleep_o,
  output logic param_valid_o,
  output logic [7:0] param_byte_o,
  output logic resp_valid_o,
  output logic [7:0] resp_code_o,
  output rfm_pkg::rfm_state_t state_o
);
  import rfm_pkg::*;

  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= `RFM_CH_0 && c <= `RFM_CH_9) r = {1'b1, c[3:0]};
    else if (c >= `RFM_CH_A && c <= `RFM_CH_F) r = {1'b1, 4'(c[3:0] + 4'h9)};
    return r;
  endfunction : hex_nib

  function automatic logic has_opt(input logic [7:0] c);
    return c >= `RFM_CMD_READ && c <= `RFM_CMD_WSAME;
  endfunction : has_opt

  function automatic logic [7:0] tag_code(input logic [1:0] tr);
    logic [7:0] r;
    r = `RFM_EC_OK;
    unique case (tr)
      `RFM_TR_OK: r = `RFM_EC_OK;
      `RFM_TR_COMM: r = `RFM_EC_COMM;
      `RFM_TR_WRT: r = `RFM_EC_WRT;
      `RFM_TR_HW: r = `RFM_EC_HW;
    endcase
    return r;
  endfunction : tag_code

  logic [1:0] ctrl_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic hresp_reg;
  logic in_frame_reg, in_frame_next;
  rfm_field_t fld_reg, fld_next;
  logic hi_half_reg, hi_next;
  logic [3:0] nib_reg, nib_next;
  logic [7:0] remain_reg, remain_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] opt_reg, opt_next;
  logic [7:0] cnt_reg;
  logic [7:0] bcc_reg;
  logic ef_par_reg, ef_frm_reg, ef_ovr_reg, ef_long_reg, ef_fmt_reg;
  logic [GAP_W-1:0] gap_reg;
  logic fe_reg;
  logic [7:0] fe_err_reg;
  rfm_state_t state_reg, state_next;
  logic [3:0] mode_reg;
  logic [7:0] acc_cmd_reg;
  logic hold_reg;
  logic field_reg, inhib_reg, sleep_reg;
  logic start_reg, stop_reg;
  logic pv_reg;
  logic [7:0] pbyte_reg;
  logic rv_reg;
  logic [7:0] resp_code_reg, resp_next;
  logic resp_fire;
  logic [31:0] status_word;

  // Register bus: zero wait states, always OKAY
  wire ahb_take = hsel_i & hready_i & htrans_i[1];
  wire addr_low = haddr_i[31:8] == 24'h000000;
  wire [7:0] a8 = haddr_i[7:0];
  wire en = ctrl_reg[`RFM_CTRL_EN_BIT];
  wire lenf = ctrl_reg[`RFM_CTRL_LEN_BIT];
  wire wr_ctrl = wr_pend_reg & (wr_addr_reg == `RFM_OFS_CTRL);
  wire [31:0] result_word = {8'h00, opt_reg, cmd_reg, resp_code_reg};
  wire [31:0] rd_word = !addr_low ? 32'h0 :
                        (a8 == `RFM_OFS_CTRL) ? {30'h0, ctrl_reg} :
                        (a8 == `RFM_OFS_STATUS) ? status_word :
                        (a8 == `RFM_OFS_RESULT) ? result_word : 32'h0;

  always_comb begin
    status_word = 32'h0;
    status_word[1:0] = state_reg;
    status_word[`RFM_ST_FIELD_BIT] = field_reg;
    status_word[`RFM_ST_INHIB_BIT] = inhib_reg;
    status_word[`RFM_ST_FRAME_BIT] = in_frame_reg;
    status_word[`RFM_ST_SLEEP_BIT] = sleep_reg;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= `RFM_CTRL_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0;
      hready_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= ahb_take & hwrite_i & addr_low;
      if (ahb_take) wr_addr_reg <= a8;
      if (ahb_take && !hwrite_i) hrdata_reg <= rd_word;
      if (wr_ctrl) ctrl_reg <= hwdata_i[1:0];
    end
  end

  // Character intake and field walk
  wire ch_ev = rx_valid_i & en;
  wire is_cr = rx_char_i == `RFM_CH_CR;
  wire start_ch = ch_ev & !in_frame_reg & (lenf ? rx_char_i == `RFM_CH_STX : !is_cr);
  wire ch_act = ch_ev & (in_frame_reg | start_ch);
  wire data_ch = lenf ? ch_ev & in_frame_reg : ch_ev & !is_cr;
  wire rfm_field_t fld_eff = (!lenf && fld_reg == FL_COUNT) ? FL_CMD : fld_reg;
  wire [4:0] hx = hex_nib(rx_char_i);
  wire pair_now = !lenf & (fld_eff != FL_PAR | !opt_reg[`RFM_OPT_CODE_BIT]);
  wire byte_ev = data_ch & (!pair_now | hi_half_reg);
  wire [7:0] byte_val = pair_now ? {nib_reg, hx[3:0]} : rx_char_i;
  wire bad_hex = data_ch & pair_now & !hx[4];
  wire end_t = ch_ev & !lenf & is_cr & in_frame_reg;
  wire end_l = data_ch & lenf & fld_eff != FL_COUNT & remain_reg == 8'h01;
  wire gap_to = in_frame_reg & (gap_reg == GAP_W'(GAP_CYCLES - 1));
  // Length framing drops a stalled frame silently
  wire frame_end = end_t | end_l | (gap_to & !lenf);
  wire frame_over = frame_end | gap_to;

  wire fp = ef_par_reg | (ch_act & rx_parity_err_i);
  wire ff = ef_frm_reg | (ch_act & rx_frame_err_i);
  wire fo = ef_ovr_reg | (ch_act & rx_overrun_err_i);
  wire long_now = ef_long_reg | (ch_act & cnt_reg == 8'(MAX_CHARS));
  wire fmt_now = ef_fmt_reg | bad_hex;
  wire [7:0] bcc_now = bcc_reg ^ ((data_ch & lenf) ? rx_char_i : 8'h00);
  wire hdr_bad = fld_eff != FL_PAR | hi_half_reg;
  wire [7:0] rx_code = fp ? `RFM_EC_PAR : ff ? `RFM_EC_FRM : fo ? `RFM_EC_OVR :
                       (end_l && bcc_now != 8'h00) ? `RFM_EC_BCC :
                       (long_now || gap_to) ? `RFM_EC_FRAME :
                       (fmt_now || hdr_bad) ? `RFM_EC_FMT : `RFM_EC_OK;

  always_comb begin
    in_frame_next = in_frame_reg | start_ch;
    fld_next = fld_reg;
    hi_next = hi_half_reg;
    nib_next = nib_reg;
    remain_next = remain_reg;
    cmd_next = cmd_reg;
    opt_next = opt_reg;
    if (data_ch && pair_now && hx[4]) begin
      hi_next = !hi_half_reg;
      nib_next = hx[3:0];
    end
    if (data_ch && lenf) remain_next = (fld_eff == FL_COUNT) ? rx_char_i : remain_reg - 8'h01;
    if (byte_ev) begin
      unique case (fld_eff)
        FL_COUNT: fld_next = FL_CMD;
        FL_CMD: begin
          cmd_next = byte_val;
          opt_next = 8'h00;
          fld_next = has_opt(byte_val) ? FL_OPT : FL_PAR;
        end
        FL_OPT: begin
          opt_next = byte_val;
          fld_next = FL_PAR;
        end
        FL_PAR: fld_next = FL_PAR;
      endcase
    end
    if (frame_over) begin
      in_frame_next = 1'b0;
      fld_next = FL_COUNT;
      hi_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_frame_reg <= 1'b0;
      fld_reg <= FL_COUNT;
      hi_half_reg <= 1'b0;
      nib_reg <= 4'h0;
      remain_reg <= 8'h00;
      cmd_reg <= 8'h00;
      opt_reg <= 8'h00;
    end else begin
      in_frame_reg <= in_frame_next;
      fld_reg <= fld_next;
      hi_half_reg <= hi_next;
      nib_reg <= nib_next;
      remain_reg <= remain_next;
      cmd_reg <= cmd_next;
      opt_reg <= opt_next;
    end
  end

  // Sticky per-frame fault flags; counter saturates past the limit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {ef_par_reg, ef_frm_reg, ef_ovr_reg, ef_long_reg, ef_fmt_reg} <= 5'h00;
      cnt_reg <= 8'h00;
      bcc_reg <= 8'h00;
      gap_reg <= '0;
    end else if (frame_over) begin
      {ef_par_reg, ef_frm_reg, ef_ovr_reg, ef_long_reg, ef_fmt_reg} <= 5'h00;
      cnt_reg <= 8'h00;
      bcc_reg <= 8'h00;
      gap_reg <= '0;
    end else begin
      {ef_par_reg, ef_frm_reg, ef_ovr_reg, ef_long_reg, ef_fmt_reg} <=
        {fp, ff, fo, long_now, fmt_now};
      if (ch_act && !long_now) cnt_reg <= cnt_reg + 8'h01;
      bcc_reg <= bcc_now;
      gap_reg <= (ch_ev || !in_frame_reg) ? '0 : gap_reg + 1'b1;
    end
  end

  // Command execution
  wire tag_resp_now = (state_reg == ST_ACCESS) & tag_done_i;
  // A tag answer owns the response slot; the frame result waits a cycle
  wire fe_go = fe_reg & !tag_resp_now;
  wire exec_ok = fe_go & (fe_err_reg == `RFM_EC_OK);
  wire fe_bad = fe_go & (fe_err_reg != `RFM_EC_OK);
  wire stop_go = exec_ok & (cmd_reg == `RFM_CMD_STOP);
  wire ack_go = exec_ok & (cmd_reg == `RFM_CMD_ACK);
  wire nak_go = exec_ok & (cmd_reg == `RFM_CMD_NAK);
  wire new_go = exec_ok & !stop_go & !ack_go & !nak_go;
  wire cmd_def = has_opt(cmd_reg) | (cmd_reg >= `RFM_CMD_SNUM && cmd_reg <= `RFM_CMD_LOCK) |
                 (cmd_reg >= `RFM_CMD_TEST && cmd_reg <= `RFM_CMD_STOP) |
                 (cmd_reg == `RFM_CMD_EAS);
  wire [3:0] opt_mode = opt_reg[`RFM_OPT_MODE_MSB:0];
  wire mode_def = opt_mode inside {`RFM_MODE_STRIG, `RFM_MODE_SAUTO, `RFM_MODE_SREP,
                  `RFM_MODE_FTRIG, `RFM_MODE_FAUTO, `RFM_MODE_FCONT, `RFM_MODE_FREP};
  wire rsv_ok = opt_reg[`RFM_OPT_RSV_MSB:`RFM_OPT_RSV_LSB] == 3'h0;
  wire code_ok = !(lenf & opt_reg[`RFM_OPT_CODE_BIT]);
  wire rep_ok = (opt_mode != `RFM_MODE_SREP) | (cmd_reg == `RFM_CMD_READ);
  wire opt_ok = !has_opt(cmd_reg) | (mode_def & rsv_ok & code_ok & rep_ok);
  wire [3:0] go_mode = has_opt(cmd_reg) ? opt_mode : `RFM_MODE_STRIG;
  wire busy = state_reg != ST_IDLE;
  wire refuse = new_go & (!cmd_def | !opt_ok | busy);
  wire start_go = new_go & cmd_def & opt_ok & !busy;
  wire go_immed = (go_mode == `RFM_MODE_STRIG) | (go_mode == `RFM_MODE_FTRIG);
  wire no_tag = start_go & go_immed & !tag_present_i;
  wire anti_mode = mode_reg[`RFM_MODE_ANTI_BIT];
  wire rep_mode = (mode_reg == `RFM_MODE_SREP) | (mode_reg == `RFM_MODE_FREP);
  wire cont_mode = mode_reg == `RFM_MODE_FCONT;
  wire [3:0] mode_next = start_go ? go_mode : mode_reg;
  wire hold_next = stop_go ? 1'b0 : hold_reg | (tag_resp_now & anti_mode);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (start_go && !no_tag) state_next = go_immed ? ST_ACCESS : ST_WAIT;
      ST_WAIT: if (tag_present_i) state_next = ST_ACCESS;
      ST_ACCESS: if (tag_resp_now) begin
        state_next = rep_mode ? ST_WAIT : cont_mode ? ST_ACK : ST_IDLE;
      end
      ST_ACK: if (ack_go) state_next = ST_WAIT;
    endcase
    if (stop_go) state_next = ST_IDLE;
  end

  always_comb begin
    resp_fire = 1'b1;
    resp_next = resp_code_reg;
    if (tag_resp_now) resp_next = tag_code(tag_result_i);
    else if (fe_bad) resp_next = fe_err_reg;
    else if (stop_go) resp_next = `RFM_EC_OK;
    else if (nak_go) resp_next = resp_code_reg;
    else if (refuse) resp_next = `RFM_EC_FMT;
    else if (no_tag) resp_next = `RFM_EC_NOTAG;
    else resp_fire = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fe_reg <= 1'b0;
      fe_err_reg <= `RFM_EC_OK;
      state_reg <= ST_IDLE;
      mode_reg <= `RFM_MODE_STRIG;
      acc_cmd_reg <= 8'h00;
      hold_reg <= 1'b0;
    end else begin
      fe_reg <= frame_end | (fe_reg & tag_resp_now);
      if (frame_end) fe_err_reg <= rx_code;
      state_reg <= state_next;
      mode_reg <= mode_next;
      if (start_go) acc_cmd_reg <= cmd_reg;
      hold_reg <= hold_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {field_reg, inhib_reg, start_reg, stop_reg, pv_reg, rv_reg} <= 6'h00;
      sleep_reg <= 1'b1;
      pbyte_reg <= 8'h00;
      resp_code_reg <= `RFM_EC_OK;
    end else begin
      field_reg <= (state_next != ST_IDLE) | hold_next;
      inhib_reg <= hold_next | ((state_next != ST_IDLE) & mode_next[`RFM_MODE_ANTI_BIT]);
      sleep_reg <= state_next == ST_IDLE;
      start_reg <= (state_next == ST_ACCESS) & (state_reg != ST_ACCESS);
      stop_reg <= stop_go & busy;
      pv_reg <= byte_ev & (fld_eff == FL_PAR) & !(lenf & remain_reg == 8'h01);
      if (byte_ev) pbyte_reg <= byte_val;
      rv_reg <= resp_fire;
      resp_code_reg <= resp_next;
    end
  end

  assign hreadyout_o = hready_reg;
  assign hresp_o = hresp_reg;
  assign hrdata_o = hrdata_reg;
  assign tag_start_o = start_reg;
  assign tag_stop_o = stop_reg;
  assign tag_cmd_o = acc_cmd_reg;
  assign tag_mode_o = mode_reg;
  assign tag_inhibit_o = inhib_reg;
  assign field_on_o = field_reg;
  assign sleep_o = sleep_reg;
  assign param_valid_o = pv_reg;
  assign param_byte_o = pbyte_reg;
  assign resp_valid_o = rv_reg;
  assign resp_code_o = resp_code_reg;
  assign state_o = state_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_notag_code: assert property (
    no_tag |=> resp_valid_o && resp_code_o == `RFM_EC_NOTAG && sleep_o)
    else $error("no-tag answer missing");
  a_stop_idle: assert property (
    stop_go |=> state_reg == ST_IDLE && resp_code_o == `RFM_EC_OK && !field_on_o)
    else $error("stop did not end execution");
  a_wait_stop: assert property (
    state_reg == ST_WAIT && stop_go |=> tag_stop_o && !tag_start_o ##1 state_reg == ST_IDLE)
    else $error("stop while waiting not honoured");
  a_ack_resume: assert property (
    state_reg == ST_ACK && !ack_go && !stop_go |=> state_reg == ST_ACK)
    else $error("left acknowledge wait early");
  a_single_sleep: assert property (
    tag_resp_now && !rep_mode && !cont_mode |=> resp_valid_o && sleep_o && !tag_start_o)
    else $error("no sleep after answer");
  a_repeat_loop: assert property (
    tag_resp_now && rep_mode |=> state_reg == ST_WAIT && resp_valid_o)
    else $error("repeat mode did not rearm");
  a_hold_field: assert property (
    hold_reg && !stop_go |=> field_on_o && tag_inhibit_o)
    else $error("served tags not held off");
  a_hex_pairs: assert property (
    param_valid_o && !lenf && !opt_reg[`RFM_OPT_CODE_BIT] |-> $past(hi_half_reg))
    else $error("hex byte from a single character");
  a_ascii_bytes: assert property (
    data_ch && !lenf && opt_reg[`RFM_OPT_CODE_BIT] && fld_eff == FL_PAR
    |=> param_valid_o && param_byte_o == $past(rx_char_i))
    else $error("character byte not passed");
  a_fault_code: assert property (
    frame_end && fp && state_reg == ST_IDLE |=> ##1 resp_valid_o && resp_code_o == `RFM_EC_PAR)
    else $error("parity fault code missing");
  a_bcc_code: assert property (
    end_l && !fp && !ff && !fo && bcc_now != 8'h00 && state_reg == ST_IDLE
    |=> ##1 resp_code_o == `RFM_EC_BCC)
    else $error("block check fault code missing");
  a_reserved_fmt: assert property (
    new_go && has_opt(cmd_reg) && !rsv_ok |=> resp_valid_o && resp_code_o == `RFM_EC_FMT)
    else $error("reserved bits not refused");
  a_ok_first: assert property (
    tag_resp_now && tag_result_i == `RFM_TR_OK |=> resp_valid_o && resp_code_o == `RFM_EC_OK)
    else $error("success code missing");

  c_cont_ack: cover property (state_reg == ST_ACK && ack_go ##1 state_reg == ST_WAIT);
  c_repeat_two: cover property (tag_resp_now && rep_mode ##[1:50] tag_resp_now);
  c_notag: cover property (no_tag);
  c_stop_wait: cover property (state_reg == ST_WAIT && stop_go);

endmodule : rfm_mode_handler

// >>> rfm_host_model.sv
// Host model that drives command characters toward the handler
`timescale 1ns/1ps
module rfm_host_model (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_char_o,
  output logic [2:0] rx_err_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
    rx_err_o = 3'h0;
  end
  // Released line shows the inverse so a stale value never looks valid
  task automatic send_char(input logic [7:0] c, input logic [2:0] e);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_char_o <= c;
    rx_err_o <= e;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o <= ~c;
    rx_err_o <= 3'h0;
  endtask : send_char
  // Terminator framing; string sent as given, then a carriage return
  task automatic send_str(input string s);
    foreach (s[i]) send_char(s[i], 3'h0);
    send_char(8'h0d, 3'h0);
  endtask : send_str
  // Length framing carries raw bytes, data code bit zero
  task automatic send_len(input logic [7:0] b[$]);
    send_char(8'h02, 3'h0);
    foreach (b[i]) send_char(b[i], 3'h0);
  endtask : send_len
endmodule : rfm_host_model

// >>> tb_rfm_mode_handler.sv
// Self-checking bench for the option-mode handler
`timescale 1ns/1ps
module tb_rfm_mode_handler;
  import rfm_pkg::*;
  logic clk_i, rstn_i, hsel_i, hwrite_i;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i;
  logic [31:0] hrdata_o, rd;
  logic hreadyout_o, hresp_o, rx_valid_i, tag_start_o, tag_stop_o, tag_inhibit_o;
  logic field_on_o, sleep_o, param_valid_o, resp_valid_o, par_on, leave;
  logic tag_present_i, tag_done_i;
  logic [1:0] tag_result_i;
  logic [2:0] rx_err;
  logic [3:0] tag_mode_o;
  logic [7:0] rx_char_i, tag_cmd_o, param_byte_o, resp_code_o;
  rfm_state_t state_o;
  logic [7:0] exp_q[$], par_q[$];
  logic [7:0] mv[4] = '{8'h00, 8'h01, 8'h08, 8'h09};
  logic [7:0] ec[4] = '{8'h00, 8'h70, 8'h71, 8'h7c};
  string bad[5] = '{"0105", "0120", "0302", "FF", "01000"};
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int cnt = 0;
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  rfm_host_model host (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i),
    .rx_err_o(rx_err));
  // Gap shortened so the idle-timeout case stays cheap
  rfm_mode_handler #(.GAP_CYCLES(200)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .rx_parity_err_i(rx_err[0]), .rx_frame_err_i(rx_err[1]), .rx_overrun_err_i(rx_err[2]),
    .tag_present_i(tag_present_i), .tag_done_i(tag_done_i), .tag_result_i(tag_result_i),
    .tag_start_o(tag_start_o), .tag_stop_o(tag_stop_o), .tag_cmd_o(tag_cmd_o),
    .tag_mode_o(tag_mode_o), .tag_inhibit_o(tag_inhibit_o), .field_on_o(field_on_o),
    .sleep_o(sleep_o), .param_valid_o(param_valid_o), .param_byte_o(param_byte_o),
    .resp_valid_o(resp_valid_o), .resp_code_o(resp_code_o), .state_o(state_o));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : ahb
  task automatic wait_q;
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    if (exp_q.size() > 0) chk("pending responses", exp_q.size(), 0);
    exp_q.delete();
  endtask : wait_q
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 10 ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  // Code ff means no response is due
  task automatic cmd(input logic [7:0] c, input logic [7:0] o, input logic [7:0] e);
    if (e != 8'hff) exp_q.push_back(e);
    host.send_str(string'({hx(c[7:4]), hx(c[3:0]), hx(o[7:4]), hx(o[3:0]), "0001"}));
  endtask : cmd
  task automatic stop;
    exp_q.push_back(8'h00);
    host.send_str("13");
    wait_q();
  endtask : stop
  always @(posedge clk_i) begin
    if (resp_valid_o === 1'b1 && exp_q.size() == 0) chk("stray code", resp_code_o, 8'hee);
    else if (resp_valid_o === 1'b1) chk("end code", resp_code_o, exp_q.pop_front());
    if (param_valid_o === 1'b1 && par_on && par_q.size() > 0)
      chk("param", param_byte_o, par_q.pop_front());
  end
  // Tag front end; a tag that leaves after service forces a fresh wait
  always @(posedge clk_i) begin
    tag_done_i <= 1'b0;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
    if (tag_stop_o === 1'b1) cnt <= 0;
    else if (tag_start_o === 1'b1) cnt <= 1 + $urandom % 4;
    else if (cnt == 1) begin
      tag_done_i <= 1'b1;
      cnt <= 0;
      if (leave) tag_present_i <= 1'b0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
  initial begin
    rstn_i <= 1'b0;
    hsel_i <= 1'b0;
    hwrite_i <= 1'b0;
    htrans_i <= 2'h0;
    hsize_i <= 3'h2;
    haddr_i <= 32'h0;
    hwdata_i <= 32'h0;
    tag_present_i <= 1'b0;
    tag_result_i <= 2'h0;
    par_on = 1'b0;
    leave = 1'b0;
    void'($urandom(4));
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl reset", rd, 32'h2);
    chk("okay resp", hresp_o, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    chk("status idle", rd, 32'h80);
    ahb(1'b0, 32'hc, 32'h0);
    chk("unmapped", rd, 32'h0);
    tag_present_i <= 1'b1;
    par_on = 1'b1;
    par_q = '{8'h00, 8'h01};
    cmd(8'h01, 8'h00, 8'h00);
    par_q = '{8'h41, 8'h42};
    exp_q.push_back(8'h00);
    host.send_str("0110AB");
    wait_q();
    par_on = 1'b0;
    chk("params left", par_q.size(), 0);
    foreach (mv[i]) begin
      cmd(8'h01, mv[i], 8'h00);
      wait_q();
      chk("sleep", sleep_o, 1'b1);
      chk("job mode", tag_mode_o, mv[i][3:0]);
      chk("job cmd", tag_cmd_o, 8'h01);
      chk("field held", field_on_o, mv[i][3]);
      chk("inhibit held", tag_inhibit_o, mv[i][3]);
      stop();
      chk("field off", field_on_o, 1'b0);
    end
    tag_present_i <= 1'b0;
    cmd(8'h01, 8'h00, 8'h72);
    cmd(8'h01, 8'h08, 8'h72);
    wait_q();
    for (int i = 9; i < 12; i += 1) begin
      cmd(8'h01, 8'(i == 9 ? 1 : i - 1), 8'hff);
      repeat (4) @(posedge clk_i);
      chk("waiting", state_o, ST_WAIT);
      stop();
      chk("idle", state_o, ST_IDLE);
    end
    leave = 1'b1;
    for (int m = 2; m < 12; m += 9) begin
      tag_present_i <= 1'b1;
      cmd(8'h01, 8'(m), 8'h00);
      wait_q();
      chk("repeat waits", state_o, ST_WAIT);
      exp_q.push_back(8'h00);
      tag_present_i <= 1'b1;
      wait_q();
      stop();
    end
    tag_present_i <= 1'b1;
    cmd(8'h01, 8'h0a, 8'h00);
    wait_q();
    chk("ack wait", state_o, ST_ACK);
    chk("inhibit", tag_inhibit_o, 1'b1);
    chk("field", field_on_o, 1'b1);
    host.send_str("11");
    repeat (4) @(posedge clk_i);
    chk("after ack", state_o, ST_WAIT);
    stop();
    leave = 1'b0;
    tag_present_i <= 1'b1;
    for (int r = 1; r < 4; r++) begin
      tag_result_i <= 2'(r);
      cmd(8'h01, 8'h00, ec[r]);
      wait_q();
    end
    tag_result_i <= 2'h0;
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(8'h10 + 8'(i));
      host.send_char(8'h30, 3'h1 << i);
      host.send_str("100");
      wait_q();
    end
    exp_q.push_back(8'h12);
    host.send_str("12");
    foreach (bad[i]) begin
      exp_q.push_back(8'h14);
      host.send_str(bad[i]);
      wait_q();
    end
    exp_q.push_back(8'h18);
    host.send_char(8'h30, 3'h0);
    wait_q();
    exp_q.push_back(8'h18);
    repeat (141) host.send_char(8'h30, 3'h0);
    host.send_char(8'h0d, 3'h0);
    wait_q();
    ahb(1'b1, 32'h0, 32'h3);
    exp_q.push_back(8'h00);
    host.send_len('{8'h03, 8'h10, 8'h00, 8'h13});
    wait_q();
    ahb(1'b0, 32'h8, 32'h0);
    chk("result reg", rd[15:0], 16'h1000);
    exp_q.push_back(8'h13);
    host.send_len('{8'h03, 8'h10, 8'h00, 8'h12});
    wait_q();
    end_of_test();
  end
endmodule : tb_rfm_mode_handler
